// [verilog/psr_regs.vh]
// Purpose: constants for the pipeline register with scan shadow
// Assumes: included by the design files by bare name
// Notes: definitions only
`ifndef PSR_REGS_VH
`define PSR_REGS_VH
`define PSR_WIDTH 8
`define PSR_SCAN_LSB 0
`define PSR_SCAN_MSB 7
`define PSR_SYNC_STAGES 2
`endif

// [verilog/psr_edge_sync.v]
// Purpose: two-flop synchroniser with rising edge detect
// Assumes: async input, one clock clk_i
// Notes: first flop is read only by the second flop
`timescale 1ns/1ps
`include "psr_regs.vh"
module psr_edge_sync
(
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // asynchronous level
   input wire async_i,
   // synchronised level and rising edge pulse
   output wire level_o,
   output wire rise_o
);
   reg meta;
   reg sync;
   reg prev;

   // two flops then one more to find the edge
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end
      else
      begin
         meta <= async_i;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level_o = sync;
   assign rise_o = sync & ~prev;
endmodule

// [verilog/psr_pipe_shadow.v]
// Purpose: 8-bit pipeline register with serial scan shadow register
// Assumes: all pins sampled by clk_i at 100 MHz; pin clocks far slower
// Notes: Function
// Function
// - 8-bit pipeline register carries D to Y
// - pipeline edge loads D or shadow by mode
// - shadow input mux: Y capture or neighbour bit
// - shift: scan_in to bit 0, bit 7 out
// - shadow drives its word onto D port
// - shadow clocked only by diagnostic clock
// - one mode input steers both registers
// - Y drives only while enable_n low
// - Y pins feed shadow parallel inputs
// - D pins input or shadow output by mode and scan
// - mode low shifts; mode high, scan low captures
// - mode low loads D; high loads shadow
// - mode high, scan high: hold, D drive, pass
// - both clocks may act in same period
`timescale 1ns/1ps
`include "psr_regs.vh"
module psr_pipe_shadow
#(
   parameter WIDTH = `PSR_WIDTH
)
(
   // clock and reset (reset only initialises the edge and control synchronisers)
   input wire clk_i,
   input wire rst_i,
   // pin clocks and controls
   input wire pipe_clock_i,
   input wire diag_clock_i,
   input wire mode_i,
   input wire scan_in_i,
   input wire y_port_output_enable_n_i,
   // d port, two-way
   input wire [WIDTH-1:0] d_in_i,
   output wire [WIDTH-1:0] d_out_o,
   output wire d_oe_o,
   // y port, two-way
   input wire [WIDTH-1:0] y_in_i,
   output wire [WIDTH-1:0] y_out_o,
   output wire y_oe_o,
   // serial output
   output wire scan_out_o
);
   reg [WIDTH-1:0] pipe;
   reg [WIDTH-1:0] shadow;
   reg [WIDTH-1:0] d_meta;
   reg [WIDTH-1:0] d_sync;
   reg [WIDTH-1:0] y_meta;
   reg [WIDTH-1:0] y_sync;
   reg [2:0] ctl_meta;
   reg [2:0] ctl_sync;
   wire pipe_rise;
   wire diag_rise;
   wire mode;
   wire scan_in;
   wire oen;
   reg [WIDTH-1:0] next_shadow;

   // pin clocks are plain inputs; edges found on clk_i
   psr_edge_sync u_pipe_edge
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pipe_clock_i),
      .level_o(),
      .rise_o(pipe_rise)
   );

   psr_edge_sync u_diag_edge
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(diag_clock_i),
      .level_o(),
      .rise_o(diag_rise)
   );

   // two-flop sync of data and controls; these line up with the edge
   // detector's second flop, so a rise sees settled data and mode
   always @(posedge clk_i)
   begin
      d_meta <= d_in_i;
      d_sync <= d_meta;
      y_meta <= y_in_i;
      y_sync <= y_meta;
      if (rst_i)
      begin
         ctl_meta <= 3'h1;
         ctl_sync <= 3'h1;
      end
      else
      begin
         ctl_meta <= {mode_i, scan_in_i, y_port_output_enable_n_i};
         ctl_sync <= ctl_meta;
      end
   end

   assign mode = ctl_sync[2];
   assign scan_in = ctl_sync[1];
   assign oen = ctl_sync[0];

   // shadow source select; hold stands in for the gated clock
   always @*
   begin
      next_shadow = shadow;
      if (!mode)
         next_shadow = {shadow[WIDTH-2:0], scan_in};
      else if (!scan_in)
         next_shadow = y_sync;
      else
         next_shadow = shadow;
   end

   // no reset on either register: contents unknown until loaded
   // the two loads are independent
   always @(posedge clk_i)
   begin
      if (diag_rise)
         shadow <= next_shadow;
      if (pipe_rise)
         pipe <= mode ? shadow : d_sync;
   end

   // output drive
   assign y_out_o = pipe;
   assign y_oe_o = ~oen;
   assign d_out_o = shadow;
   assign d_oe_o = mode & scan_in;
   // bit 7 while shifting, else pass-through, for chaining
   assign scan_out_o = mode ? scan_in : shadow[WIDTH-1];
endmodule

// [verif/psr_far_model.sv]
// Purpose: far side of D and Y pins. Assumes: no pull-ups.
// Notes: a released Y shows the inverse of the current pipeline word
`timescale 1ns/1ps
module psr_far(input wire [7:0] d_sys_i,d_dev_i,y_dev_i,
 input wire d_oe_i,y_oe_i,output wire [7:0] d_o,y_o);
// system backs off D whenever the shadow drives it
assign d_o=d_oe_i?d_dev_i:d_sys_i;
assign y_o=y_oe_i?y_dev_i:~y_dev_i;
endmodule

// [verif/psr_checker_properties.sv]
// Purpose: pin checks. Assumes: pins held 4+ clk.
// Notes: synchronisers delay enables by 2-3 clk
`timescale 1ns/1ps
module psr_checker(input wire clk_i,rst_i,diag_clock_i,mode_i,scan_in_i,
 y_port_output_enable_n_i,d_oe_o,y_oe_o,scan_out_o,
 input wire [7:0] d_out_o);
wire hs=mode_i&scan_in_i; // hold and drive
default clocking @(posedge clk_i);endclocking
default disable iff(rst_i);
property p_yon;(!y_port_output_enable_n_i)[*4]|->y_oe_o;endproperty
a_yon:assert property(p_yon)else $error("y off");
property p_don;hs[*4]|->d_oe_o&&scan_out_o;endproperty
a_don:assert property(p_don)else $error("d off");
property p_doff;(!mode_i)[*4]|->!d_oe_o;endproperty
a_doff:assert property(p_doff)else $error("d on");
property p_so;(!mode_i)[*6]|->scan_out_o===d_out_o[7];endproperty
a_so:assert property(p_so)else $error("scan out");
property p_dst;(!diag_clock_i)[*6]|->$stable(d_out_o);endproperty
a_dst:assert property(p_dst)else $error("shadow moved");
property p_hold;hs[*8]|->$stable(d_out_o);endproperty
a_hold:assert property(p_hold)else $error("no hold");
endmodule
bind psr_pipe_shadow psr_checker chk_u(.clk_i(clk_i),.rst_i(rst_i),
 .diag_clock_i(diag_clock_i),.mode_i(mode_i),.scan_in_i(scan_in_i),
 .y_port_output_enable_n_i(y_port_output_enable_n_i),.d_oe_o(d_oe_o),
 .y_oe_o(y_oe_o),.scan_out_o(scan_out_o),.d_out_o(d_out_o));

// [verif/pipeline_register_with_scan_shadow_test.sv]
// Purpose: scan shadow bench. Assumes: pin clock ~110 ns.
// Notes: pin data held 50 ns around each pin edge
`timescale 1ns/1ps
module pipeline_register_with_scan_shadow_test;
reg clk_i=0,rst_i=1,pc=0,dc=0,md=0,si=0,oen=1;
reg [7:0] ds=8'h3c;
wire [7:0] d,y,dq,yq;
wire doe,yoe,so;
integer num_errors=0,total_checks=0;
psr_pipe_shadow dut_u(.clk_i(clk_i),.rst_i(rst_i),.pipe_clock_i(pc),
 .diag_clock_i(dc),.mode_i(md),.scan_in_i(si),
 .y_port_output_enable_n_i(oen),.d_in_i(d),.d_out_o(dq),.d_oe_o(doe),
 .y_in_i(y),.y_out_o(yq),.y_oe_o(yoe),.scan_out_o(so));
psr_far far_u(.d_sys_i(ds),.d_dev_i(dq),.y_dev_i(yq),.d_oe_i(doe),
 .y_oe_i(yoe),.d_o(d),.y_o(y));
initial forever #5 clk_i=~clk_i;
task chk(input [47:0] n,input [7:0] s,e);
begin total_checks=total_checks+1;
if(s!==e)begin num_errors=num_errors+1;
$display("Error %0s exp %h seen %h",n,e,s);end end endtask
// one pin clock pulse: p=1 pipeline, p=0 diagnostic
task tick(input p);begin repeat(5)@(negedge clk_i);
if(p)pc=1;else dc=1;repeat(6)@(negedge clk_i);pc=0;dc=0;end endtask
task shift(input [7:0] w);integer i;begin md=0;
for(i=7;i>=0;i=i-1)begin si=w[i];tick(0);end end endtask
task report_and_stop;begin
$display("checks %0d errors %0d",total_checks,num_errors);
if(num_errors==0&&total_checks>0)$display("== PASSED ==");
else $display("== FAILED ==");$finish;end endtask
initial begin #100000;num_errors=num_errors+1;report_and_stop;end
task t_shift;begin shift(8'ha5);chk("shift",dq,8'ha5);
chk("sout",so,8'h01);
chk("doff",doe,8'h00);
$display("t_shift done");end endtask
task t_pload;begin tick(1);chk("pload",yq,8'h3c);
$display("t_pload done");end endtask
task t_cap;begin oen=0;md=1;si=0;tick(0);chk("yoe",yoe,8'h01);
chk("cap",dq,8'h3c);
chk("capoff",doe,8'h00);
$display("t_cap done");end endtask
task t_pshad;begin shift(8'h5a);md=1;tick(1);chk("pshad",yq,8'h5a);
$display("t_pshad done");end endtask
// scan_in high passes straight to scan_out so chained parts see it
task t_hold;begin si=1;tick(0);chk("hold",dq,8'h5a);
chk("doe",doe,8'h01);
chk("drive",d,8'h5a);
chk("pass",so,8'h01);
$display("t_hold done");end endtask
// both pin clocks rise together: shift and D load in one period
task t_both;begin md=0;si=1;ds=8'h96;repeat(5)@(negedge clk_i);
pc=1;dc=1;repeat(6)@(negedge clk_i);pc=0;dc=0;
chk("bshift",dq,8'hb5);
chk("bload",yq,8'h96);
oen=1;repeat(4)@(negedge clk_i);chk("yoff",yoe,8'h00);
$display("t_both done");end endtask
initial begin repeat(16)@(negedge clk_i);rst_i=0;
repeat(4)@(negedge clk_i);
t_shift;t_pload;t_cap;t_pshad;t_hold;t_both;
report_and_stop;end
endmodule
